// ---- hdl/tmr_map.vh ----
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// Notes on behaviour
// RULE1: Control bits 7-4 pick clock: off, system, fast, external, slow osc, comparator.
// RULE2: Codes 1000-1101 count rising or falling edges of three pins; others are stopped.
// RULE3: Emulator halt stops the timer clock except when the fast oscillator is selected.
// RULE4: Control bits 3-2 route output: off, port B pin two, A pin three, B pin four.
// RULE5: Control bit 1 picks period mode (0) or PWM mode (1); resets to 0.
// RULE6: Control bit 0 inverts the timer output before the pin; resets to 0.
// RULE7: Eight-bit counter is readable and writable, and clears to 0x00 on reset.
// RULE8: Divider bit 7 picks 8-bit PWM, or 6/7-bit set by a build option.
// RULE9: Clock passes prescaler (1/4/16/64, bits 6-5) then five-bit scaler (bits 4-0).
// RULE10: Counter meets limit: period mode restarts and toggles; PWM mode sets duty point.

// Register addresses
`define TMR_ADDR_CTRL      8'h30
`define TMR_ADDR_COUNT     8'h31
`define TMR_ADDR_DIV       8'h32
`define TMR_ADDR_LIMIT     8'h33

// Reset values
`define TMR_CTRL_RST       8'h00
`define TMR_COUNT_RST      8'h00
`define TMR_DIV_RST        8'h00
`define TMR_LIMIT_RST      8'h00

// Control field positions
`define TMR_CTRL_SRC_HI    7
`define TMR_CTRL_SRC_LO    4
`define TMR_CTRL_ROUTE_HI  3
`define TMR_CTRL_ROUTE_LO  2
`define TMR_CTRL_MODE_BIT  1
`define TMR_CTRL_INV_BIT   0

// Divider field positions
`define TMR_DIV_RES_BIT    7
`define TMR_DIV_PRE_HI     6
`define TMR_DIV_PRE_LO     5
`define TMR_DIV_SCL_HI     4
`define TMR_DIV_SCL_LO     0

// Clock source codes
`define TMR_SRC_OFF        4'h0
`define TMR_SRC_SYS        4'h1
`define TMR_SRC_FAST       4'h2
`define TMR_SRC_EXT        4'h3
`define TMR_SRC_SLOW       4'h4
`define TMR_SRC_CMP        4'h5
`define TMR_SRC_PA0_RISE   4'h8
`define TMR_SRC_PA0_FALL   4'h9
`define TMR_SRC_PB0_RISE   4'hA
`define TMR_SRC_PB0_FALL   4'hB
`define TMR_SRC_PA4_RISE   4'hC
`define TMR_SRC_PA4_FALL   4'hD

// Output routing codes
`define TMR_ROUTE_OFF      2'h0
`define TMR_ROUTE_PB2      2'h1
`define TMR_ROUTE_PA3      2'h2
`define TMR_ROUTE_PB4      2'h3

// Prescaler codes and terminal counts
`define TMR_PRE_DIV1       2'h0
`define TMR_PRE_DIV4       2'h1
`define TMR_PRE_DIV16      2'h2
`define TMR_PRE_DIV64      2'h3
`define TMR_PRE_END1       6'h00
`define TMR_PRE_END4       6'h03
`define TMR_PRE_END16      6'h0F
`define TMR_PRE_END64      6'h3F

// PWM resolution masks
`define TMR_RES8_MASK      8'hFF
`define TMR_RES7_MASK      8'h7F
`define TMR_RES6_MASK      8'h3F

// Source vector positions
`define TMR_IN_FAST        0
`define TMR_IN_EXT         1
`define TMR_IN_SLOW        2
`define TMR_IN_CMP         3
`define TMR_IN_PA0         4
`define TMR_IN_PB0         5
`define TMR_IN_PA4         6
`define TMR_IN_COUNT       7

`endif

// ---- hdl/tmr_clk_select.v ----
`timescale 1ns/1ns
`include "tmr_map.vh"

module tmr_clk_select #(
  parameter fast_osc_doubling_option = 1'b0
) (
  input  wire       mclk_i,
  input  wire       nrst_i,
  input  wire [6:0] src_raw_i,
  input  wire [3:0] src_sel_i,
  input  wire       emu_halt_i,
  output wire       tick_o
);

  wire [6:0] rise;
  wire [6:0] fall;
  reg        next_tick;
  reg        tick;
  reg        raw_tick;

  // Two-flop synchroniser and edge detector per source
  genvar i;
  generate
    for (i = 0; i < `TMR_IN_COUNT; i = i + 1) begin : g_src
      reg meta;
      reg sync;
      reg last;
      always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta <= 1'b0;
          sync <= 1'b0;
          last <= 1'b0;
        end else begin
          meta <= src_raw_i[i];
          sync <= meta;
          last <= sync;
        end
      end
      assign rise[i] = sync & ~last;
      assign fall[i] = ~sync & last;
    end
  endgenerate

  // Sources must run below half the system clock to be seen
  always @* begin
    raw_tick = 1'b0;
    case (src_sel_i)
      `TMR_SRC_OFF:      raw_tick = 1'b0;                         // RULE1
      `TMR_SRC_SYS:      raw_tick = 1'b1;                         // RULE1
      `TMR_SRC_FAST: begin
        if (fast_osc_doubling_option)
          raw_tick = rise[`TMR_IN_FAST] | fall[`TMR_IN_FAST];     // RULE1
        else
          raw_tick = rise[`TMR_IN_FAST];
      end
      `TMR_SRC_EXT:      raw_tick = rise[`TMR_IN_EXT];            // RULE1
      `TMR_SRC_SLOW:     raw_tick = rise[`TMR_IN_SLOW];           // RULE1
      `TMR_SRC_CMP:      raw_tick = rise[`TMR_IN_CMP];            // RULE1
      `TMR_SRC_PA0_RISE: raw_tick = rise[`TMR_IN_PA0];            // RULE2
      `TMR_SRC_PA0_FALL: raw_tick = fall[`TMR_IN_PA0];            // RULE2
      `TMR_SRC_PB0_RISE: raw_tick = rise[`TMR_IN_PB0];            // RULE2
      `TMR_SRC_PB0_FALL: raw_tick = fall[`TMR_IN_PB0];            // RULE2
      `TMR_SRC_PA4_RISE: raw_tick = rise[`TMR_IN_PA4];            // RULE2
      `TMR_SRC_PA4_FALL: raw_tick = fall[`TMR_IN_PA4];            // RULE2
      default:           raw_tick = 1'b0;                         // RULE2
    endcase
  end

  // Halt freezes every source but the fast oscillator
  always @* begin
    next_tick = raw_tick;
    if (emu_halt_i && (src_sel_i != `TMR_SRC_FAST))
      next_tick = 1'b0;                                           // RULE3
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      tick <= 1'b0;
    else
      tick <= next_tick;
  end

  assign tick_o = tick;

endmodule

// ---- hdl/tmr_timer2.v ----
`timescale 1ns/1ns
`include "tmr_map.vh"

module tmr_timer2 #(
  parameter fast_osc_doubling_option = 1'b0,
  parameter reduced_pwm_width_option = 1'b0
) (
  input  wire       mclk_i,
  input  wire       nrst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output wire [7:0] rdata_o,
  input  wire       fast_internal_oscillator_i,
  input  wire       external_oscillator_i,
  input  wire       slow_internal_oscillator_i,
  input  wire       comparator_out_i,
  input  wire       port_a_pin_zero_i,
  input  wire       port_b_pin_zero_i,
  input  wire       port_a_pin_four_i,
  input  wire       in_circuit_emulator_halt_i,
  output wire       port_b_pin_two_o,
  output wire       port_b_pin_two_oe_o,
  output wire       port_a_pin_three_o,
  output wire       port_a_pin_three_oe_o,
  output wire       port_b_pin_four_o,
  output wire       port_b_pin_four_oe_o,
  output wire       timer_level_o
);

  // Software-visible registers
  reg  [7:0] timer_control;
  reg  [7:0] timer_count_value;
  reg  [7:0] timer_divider_setup;
  reg  [7:0] timer_limit_value;

  // Read path
  reg  [7:0] rdata;
  reg  [7:0] next_rdata;

  // Divider chain
  reg  [5:0] pre_cnt;
  reg  [5:0] pre_end;
  reg  [4:0] scl_cnt;
  wire       tick;
  wire       pre_done;
  wire       step;

  // Counter and output level
  reg  [7:0] next_count;
  reg  [7:0] res_mask;
  reg        period_level;
  reg        next_period_level;
  reg        pwm_level;
  wire       limit_hit;
  wire       out_level;
  reg        level_q;

  // Decoded fields
  wire [3:0] src_sel;
  wire [1:0] route;
  wire       pwm_mode;
  wire       invert;
  wire       res_reduced;
  wire [1:0] pre_sel;
  wire [4:0] scl_end;

  // Address matches, shared by the write and read paths
  wire       sel_ctrl;
  wire       sel_count;
  wire       sel_div;
  wire       sel_limit;

  // Bus strobes per register
  wire       wr_ctrl;
  wire       wr_count;
  wire       wr_div;
  wire       wr_limit;

  // Pin drive flops, one pair per routable pin
  localparam PIN_PB2   = 0;
  localparam PIN_PA3   = 1;
  localparam PIN_PB4   = 2;
  localparam PIN_COUNT = 3;
  wire [2:0] pin_val;
  wire [2:0] pin_oe;
  wire [5:0] pin_codes;
  wire [6:0] src_raw;

  // Counter helpers
  wire       period_match;
  wire [7:0] count_plus_one;
  wire [7:0] masked_count;
  wire [7:0] masked_limit;

  assign src_sel     = timer_control[`TMR_CTRL_SRC_HI:`TMR_CTRL_SRC_LO];
  assign route       = timer_control[`TMR_CTRL_ROUTE_HI:`TMR_CTRL_ROUTE_LO];
  assign pwm_mode    = timer_control[`TMR_CTRL_MODE_BIT];
  assign invert      = timer_control[`TMR_CTRL_INV_BIT];
  assign res_reduced = timer_divider_setup[`TMR_DIV_RES_BIT];
  assign pre_sel     = timer_divider_setup[`TMR_DIV_PRE_HI:`TMR_DIV_PRE_LO];
  assign scl_end     = timer_divider_setup[`TMR_DIV_SCL_HI:`TMR_DIV_SCL_LO];

  // Address decode, one match per register
  assign sel_ctrl  = (addr_i == `TMR_ADDR_CTRL);
  assign sel_count = (addr_i == `TMR_ADDR_COUNT);
  assign sel_div   = (addr_i == `TMR_ADDR_DIV);
  assign sel_limit = (addr_i == `TMR_ADDR_LIMIT);

  // Write strobes; unmapped writes are dropped
  assign wr_ctrl  = wr_i && sel_ctrl;
  assign wr_count = wr_i && sel_count;
  assign wr_div   = wr_i && sel_div;
  assign wr_limit = wr_i && sel_limit;

  // Raw clock sources, all asynchronous to the system clock
  assign src_raw[`TMR_IN_FAST] = fast_internal_oscillator_i;
  assign src_raw[`TMR_IN_EXT]  = external_oscillator_i;
  assign src_raw[`TMR_IN_SLOW] = slow_internal_oscillator_i;
  assign src_raw[`TMR_IN_CMP]  = comparator_out_i;
  assign src_raw[`TMR_IN_PA0]  = port_a_pin_zero_i;
  assign src_raw[`TMR_IN_PB0]  = port_b_pin_zero_i;
  assign src_raw[`TMR_IN_PA4]  = port_a_pin_four_i;

  // Source selection turns the chosen clock into count ticks
  tmr_clk_select #(
    .fast_osc_doubling_option (fast_osc_doubling_option)
  ) u_clk_select (
    .mclk_i     (mclk_i),
    .nrst_i     (nrst_i),
    .src_raw_i  (src_raw),
    .src_sel_i  (src_sel),
    .emu_halt_i (in_circuit_emulator_halt_i),
    .tick_o     (tick)
  );

  // Control register
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_control <= `TMR_CTRL_RST;                    // RULE5
    end else if (wr_ctrl) begin
      timer_control <= wdata_i;                          // RULE1
    end
  end

  // Write-only divider setup; bit 7 also trims the PWM width
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      timer_divider_setup <= `TMR_DIV_RST;               // RULE9
    else if (wr_div)
      timer_divider_setup <= wdata_i;                    // RULE8
  end

  // Write-only limit, the compare point for both modes
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      timer_limit_value <= `TMR_LIMIT_RST;               // RULE10
    else if (wr_limit)
      timer_limit_value <= wdata_i;                      // RULE10
  end

  // Prescaler terminal count from the two-bit select
  always @* begin
    pre_end = `TMR_PRE_END1;
    case (pre_sel)
      `TMR_PRE_DIV1:  pre_end = `TMR_PRE_END1;           // RULE9
      `TMR_PRE_DIV4:  pre_end = `TMR_PRE_END4;           // RULE9
      `TMR_PRE_DIV16: pre_end = `TMR_PRE_END16;          // RULE9
      `TMR_PRE_DIV64: pre_end = `TMR_PRE_END64;          // RULE9
      default:        pre_end = `TMR_PRE_END1;
    endcase
  end

  // Compare with >= so a smaller ratio written mid-count recovers at once
  assign pre_done = tick && (pre_cnt >= pre_end);
  assign step     = pre_done && (scl_cnt >= scl_end);    // RULE9

  // Prescaler and scaler restart when software loads the counter
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt <= 6'h00;
      scl_cnt <= 5'h00;
    end else if (wr_count) begin
      pre_cnt <= 6'h00;
      scl_cnt <= 5'h00;
    end else if (tick) begin
      if (pre_done) begin
        pre_cnt <= 6'h00;
        if (step)
          scl_cnt <= 5'h00;
        else
          scl_cnt <= scl_cnt + 5'h01;                    // RULE9
      end else begin
        pre_cnt <= pre_cnt + 6'h01;                      // RULE9
      end
    end
  end

  // PWM wrap width
  always @* begin
    res_mask = `TMR_RES8_MASK;
    if (res_reduced) begin
      if (reduced_pwm_width_option)
        res_mask = `TMR_RES7_MASK;                       // RULE8
      else
        res_mask = `TMR_RES6_MASK;                       // RULE8
    end
  end

  // Match on all eight bits; only PWM narrows the compare
  assign limit_hit      = (timer_count_value == timer_limit_value);
  assign count_plus_one = timer_count_value + 8'h01;

  // A software load on the same edge hides the match
  assign period_match = step && !pwm_mode && limit_hit && !wr_count;  // RULE10

  // Next counter value; a software write wins over a step
  always @* begin
    next_count = timer_count_value;
    if (wr_count) begin
      next_count = wdata_i;                              // RULE7
    end else if (period_match) begin
      next_count = 8'h00;                                // RULE10
    end else if (step) begin
      if (pwm_mode)
        next_count = count_plus_one & res_mask;          // RULE8
      else
        next_count = count_plus_one;
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      timer_count_value <= `TMR_COUNT_RST;               // RULE7
    else
      timer_count_value <= next_count;
  end

  // Period mode toggles on each match
  always @* begin
    next_period_level = period_level;
    if (period_match)
      next_period_level = ~period_level;                 // RULE10
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      period_level <= 1'b0;
    else
      period_level <= next_period_level;
  end

  // Both sides masked so a reduced width ignores the upper limit bits
  assign masked_count = timer_count_value & res_mask;
  assign masked_limit = timer_limit_value & res_mask;

  // PWM high while count is below the limit; limit zero keeps it low
  always @* begin
    pwm_level = (masked_count < masked_limit);           // RULE10
  end

  // Mode picks the level, then optional inversion
  assign out_level = (pwm_mode ? pwm_level : period_level) ^ invert;  // RULE5 RULE6

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      level_q <= 1'b0;
    else
      level_q <= out_level;
  end

  // Route code that selects each pin, lowest pin first
  assign pin_codes = {`TMR_ROUTE_PB4, `TMR_ROUTE_PA3, `TMR_ROUTE_PB2};

  // One flop pair per pin, fed from the same level as the status flop
  // so pin and status never disagree; unselected pins are released low
  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p = p + 1) begin : g_pin
      reg val_q;
      reg oe_q;
      always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          val_q <= 1'b0;
          oe_q  <= 1'b0;
        end else if (route == pin_codes[2*p+1 -: 2]) begin
          val_q <= out_level;                            // RULE4
          oe_q  <= 1'b1;                                 // RULE4
        end else begin
          val_q <= 1'b0;
          oe_q  <= 1'b0;
        end
      end
      assign pin_val[p] = val_q;
      assign pin_oe[p]  = oe_q;
    end
  endgenerate

  // Read mux; write-only and unmapped addresses read as zero
  always @* begin
    next_rdata = 8'h00;
    if (rd_i) begin
      if (sel_ctrl)
        next_rdata = timer_control;                      // RULE5
      else if (sel_count)
        next_rdata = timer_count_value;                  // RULE7
      else if (sel_div || sel_limit)
        next_rdata = 8'h00;                              // RULE9
      else
        next_rdata = 8'h00;
    end
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  assign rdata_o               = rdata;
  assign port_b_pin_two_o      = pin_val[PIN_PB2];
  assign port_b_pin_two_oe_o   = pin_oe[PIN_PB2];
  assign port_a_pin_three_o    = pin_val[PIN_PA3];
  assign port_a_pin_three_oe_o = pin_oe[PIN_PA3];
  assign port_b_pin_four_o     = pin_val[PIN_PB4];
  assign port_b_pin_four_oe_o  = pin_oe[PIN_PB4];
  assign timer_level_o         = level_q;

endmodule

// ---- sim/tmr_timer2_monitor.sv ----
`timescale 1ns/1ns
module tmr_timer2_monitor (
  input wire       mclk_i,
  input wire       nrst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       in_circuit_emulator_halt_i,
  input wire       port_b_pin_two_o,
  input wire       port_b_pin_two_oe_o,
  input wire       port_a_pin_three_o,
  input wire       port_a_pin_three_oe_o,
  input wire       port_b_pin_four_o,
  input wire       port_b_pin_four_oe_o,
  input wire       timer_level_o
);
  reg  [7:0] ctrl;
  wire [2:0] oe  = {port_b_pin_four_oe_o, port_a_pin_three_oe_o, port_b_pin_two_oe_o};
  wire [2:0] pin = {port_b_pin_four_o, port_a_pin_three_o, port_b_pin_two_o};
  wire [2:0] route = (ctrl[3:2] == 2'h0) ? 3'h0 : 3'h1 << (ctrl[3:2] - 2'h1);
  // Shadow of control, rebuilt from bus writes
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      ctrl <= 8'h00;
    else if (wr_i && addr_i == 8'h30)
      ctrl <= wdata_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Pins are registered, so routing needs a few quiet cycles
  sequence ctrl_held;
    !(wr_i && addr_i == 8'h30) [*3];
  endsequence
  sequence halt_quiet;
    (in_circuit_emulator_halt_i && !wr_i && ctrl[7:4] != 4'h2) [*5];
  endsequence
  rdata_idle_a:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
  ctrl_readback_a:
    assert property (rd_i && addr_i == 8'h30 |=> rdata_o == $past(ctrl))
      else $error("control readback wrong");
  wo_read_zero_a:
    assert property (rd_i && (addr_i == 8'h32 || addr_i == 8'h33) |=> rdata_o == 8'h00)
      else $error("write-only register readable");
  count_readback_a:
    assert property ((wr_i && addr_i == 8'h31 && ctrl[7:4] == 4'h0) ##1
      (rd_i && addr_i == 8'h31) |=> rdata_o == $past(wdata_i, 2))
      else $error("count readback wrong");
  route_enable_a:
    assert property (ctrl_held |-> oe == route) else $error("pin enable wrong");
  unsel_low_a:
    assert property ((pin & ~oe) == 3'h0) else $error("undriven pin not low");
  pin_level_a:
    assert property (oe != 3'h0 && $stable(oe) |-> pin == (oe & {3{timer_level_o}}))
      else $error("pin value not level");
  halt_freeze_a:
    assert property (halt_quiet |-> $stable(timer_level_o)) else $error("halt did not freeze");
endmodule

bind tmr_timer2 tmr_timer2_monitor mon (
  .mclk_i                     (mclk_i),
  .nrst_i                     (nrst_i),
  .addr_i                     (addr_i),
  .wdata_i                    (wdata_i),
  .wr_i                       (wr_i),
  .rd_i                       (rd_i),
  .rdata_o                    (rdata_o),
  .in_circuit_emulator_halt_i (in_circuit_emulator_halt_i),
  .port_b_pin_two_o           (port_b_pin_two_o),
  .port_b_pin_two_oe_o        (port_b_pin_two_oe_o),
  .port_a_pin_three_o         (port_a_pin_three_o),
  .port_a_pin_three_oe_o      (port_a_pin_three_oe_o),
  .port_b_pin_four_o          (port_b_pin_four_o),
  .port_b_pin_four_oe_o       (port_b_pin_four_oe_o),
  .timer_level_o              (timer_level_o)
);

// ---- sim/tmr_pin_model.sv ----
`timescale 1ns/1ns
// Far-side pins: line k gives k+1 pulses per burst, idle low between bursts
module tmr_pin_model (
  input  wire       mclk_i,
  input  wire       go_i,
  output reg  [6:0] line_o
);
  integer i;
  initial line_o = 7'h00;
  // Levels last 4 clocks so the synchroniser always sees them
  always begin
    @(posedge go_i);
    for (i = 1; i <= 7; i = i + 1) begin
      repeat (4) @(posedge mclk_i);
      line_o <= 7'h7F << (i - 1);
      repeat (4) @(posedge mclk_i);
      line_o <= 7'h00;
    end
  end
endmodule

// ---- sim/test_tmr_timer2.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_tmr_timer2;
  reg         mclk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [7:0]  addr_i = 8'h00;
  reg  [7:0]  wdata_i = 8'h00;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         halt = 1'b0;
  reg         go = 1'b0;
  reg         rd_q = 1'b0;
  wire [7:0]  rdata_o;
  wire [6:0]  line;
  wire [2:0]  oe;
  wire [2:0]  pin;
  wire        level;
  logic [7:0] expq[$];
  integer     fail_count = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     seed = 32'h8cc3;
  integer     i;
  integer     n;
  reg  [7:0]  c, l, m, ex, k;
  reg  [2:0]  r;
  reg         x, lv;

  tmr_timer2 uut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fast_internal_oscillator_i(line[0]), .external_oscillator_i(line[1]),
    .slow_internal_oscillator_i(line[2]), .comparator_out_i(line[3]),
    .port_a_pin_zero_i(line[4]), .port_b_pin_zero_i(line[5]),
    .port_a_pin_four_i(line[6]), .in_circuit_emulator_halt_i(halt),
    .port_b_pin_two_o(pin[0]), .port_b_pin_two_oe_o(oe[0]),
    .port_a_pin_three_o(pin[1]), .port_a_pin_three_oe_o(oe[1]),
    .port_b_pin_four_o(pin[2]), .port_b_pin_four_oe_o(oe[2]),
    .timer_level_o(level)
  );
  tmr_pin_model pm (.mclk_i(mclk_i), .go_i(go), .line_o(line));

  initial forever #5 mclk_i = ~mclk_i;

  task print_verdict;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      expq.push_back(e);
      @(posedge mclk_i);
      rd_i <= 1'b0;
    end
  endtask

  // Read issued in the cycle right after the write
  task wrrd(input [7:0] a, input [7:0] d, input [7:0] e);
    begin
      wr(a, d);
      rd_i <= 1'b1;
      expq.push_back(e);
      @(posedge mclk_i);
      rd_i <= 1'b0;
    end
  endtask

  // Counts expected from one burst; halt leaves only the fast oscillator
  function [7:0] src_exp(input [3:0] s, input h);
    begin
      case (s)
        4'h2: src_exp = 8'h01;
        4'h3, 4'h4, 4'h5: src_exp = {4'h0, s} - 8'h01;
        4'h8, 4'h9: src_exp = 8'h05;
        4'hA, 4'hB: src_exp = 8'h06;
        4'hC, 4'hD: src_exp = 8'h07;
        default: src_exp = 8'h00;
      endcase
      if (h && s != 4'h2)
        src_exp = 8'h00;
    end
  endfunction

  // Read data is taken in the one cycle it stands
  always @(posedge mclk_i) begin
    rd_q <= rd_i;
    cycles <= cycles + 1;
    if (rd_q) begin
      ex = expq.pop_front();
      `CHK(rdata_o, ex)
    end
    if (cycles == 20000) begin
      fail_count++;
      print_verdict;
    end
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h00);
    wrrd(8'h40, 8'h5A, 8'h00);
    for (i = 0; i < 4; i++) begin
      c = $random(seed);
      wrrd(8'h31, c, c);
      wrrd(8'h30, {4'h0, c[3:0]}, {4'h0, c[3:0]});
    end
    // Every source code but the system clock, free running then halted
    wr(8'h33, 8'hFF);
    wr(8'h32, 8'h00);
    for (i = 0; i < 32; i++) begin
      halt <= i[4];
      if (i[3:0] != 4'h1) begin
        wr(8'h30, {i[3:0], 4'h0});
        wr(8'h31, 8'h00);
        go <= 1'b1;
        repeat (70) @(posedge mclk_i);
        go <= 1'b0;
        rd(8'h31, src_exp(i[3:0], i[4]));
      end
    end
    halt <= 1'b0;
    // Step lands between n-2 and n+6 clocks after the count write
    for (i = 0; i < 4; i++) begin
      m = 8'h10 | ($random(seed) & 8'h0F);
      n = (4 ** i) * (m + 1);
      wr(8'h32, {1'b0, i[1:0], m[4:0]});
      wr(8'h30, 8'h1C); // routed to the fourth pin so period toggles reach it
      wr(8'h31, 8'h40);
      repeat (n - 4) @(posedge mclk_i);
      rd(8'h31, 8'h40);
      repeat (6) @(posedge mclk_i);
      rd(8'h31, 8'h41);
    end
    // Period mode: level toggles every limit+1 steps
    wr(8'h32, 8'h00);
    for (i = 0; i < 3; i++) begin
      l = (i == 0) ? 8'h00 : ($random(seed) & 8'h1F);
      wr(8'h33, l);
      wr(8'h31, 8'h00);
      #1 lv = level;
      for (n = 0; level === lv && n < 600; n++) @(posedge mclk_i) #1;
      lv = level;
      for (n = 0; level === lv && n < 600; n++) @(posedge mclk_i) #1;
      `CHK(n, l + 1)
    end
    // PWM with the timer stopped: level fixed by count against limit
    for (i = 0; i < 8; i++) begin
      c = $random(seed);
      l = (i == 0) ? 8'h00 : $random(seed);
      m = $random(seed);
      wr(8'h32, {m[7], 7'h00});
      wr(8'h33, l);
      // Stop the timer before loading, or a running source moves the count
      wr(8'h30, {4'h0, i[1:0], 1'b1, m[0]});
      wr(8'h31, c);
      repeat (3) @(posedge mclk_i);
      #1 k = m[7] ? 8'h3F : 8'hFF;
      x = ((c & k) < (l & k)) ^ m[0];
      r = (i[1:0] == 2'h0) ? 3'h0 : 3'h1 << (i[1:0] - 2'h1);
      `CHK(level, x)
      `CHK(oe, r)
      `CHK(pin, r & {3{x}})
    end
    // Second reset in mid-run
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h00);
    `CHK(oe, 3'h0)
    repeat (3) @(posedge mclk_i);
    print_verdict;
  end
endmodule
